// File: logic/dsg_clock_gate.v
// glitch-free clock gating cell: enable captured on the falling edge of the clock
module dsg_clock_gate (
	// clock and enable
	input  wire clk_in,
	input  wire enable,
	// gated clock
	output wire clk_out
);
	reg en_reg;

	// enable retimed on the falling edge, so it only moves while the clock is low
	// a flop instead of a latch: half a cycle of lag, but no open transparent window
	always @(negedge clk_in) begin
		en_reg <= enable;
	end

	assign clk_out = clk_in & en_reg;
endmodule

// File: logic/dsg_consts.vh
// constants for the deep-sleep clock gating block
`ifndef DSG_CONSTS_VH
`define DSG_CONSTS_VH
`define DSG_OFF_RUN_GATE    12'h100
`define DSG_OFF_SLEEP_GATE  12'h110
`define DSG_OFF_DEEP_GATE   12'h124
`define DSG_OFF_RUN_CFG     12'h060
`define DSG_OFF_POWER_MODE  12'h200
`define DSG_OFF_INT_STATUS  12'h204
`define DSG_OFF_INT_MASK    12'h208
`define DSG_OFF_ACTIVE      12'h20c
`define DSG_GATE_MASK       32'h010f1037
`define DSG_GATE_RESET      32'h00000000
`define DSG_BIT_COMPARATOR0 24
`define DSG_BIT_COUNTER0    16
`define DSG_BIT_TWO_WIRE0   12
`define DSG_BIT_SYNC0       4
`define DSG_BIT_ASYNC0      0
`define DSG_BIT_AUTO_GATE   27
`define DSG_MODE_RUN        2'h0
`define DSG_MODE_SLEEP      2'h1
`define DSG_MODE_DEEP       2'h2
`define DSG_INT_FAULT       0
`define DSG_INT_CHANGE      1
`define DSG_INT_MASK        32'h00000003
`define DSG_RESP_OKAY       2'h0
`define DSG_RESP_SLVERR     2'h2
`define DSG_RESP_DECERR     2'h3
`define DSG_NUM_PERIPH      12
`endif

// File: logic/dsg_top.v
// deep-sleep clock gating control with axi4-lite registers
//
// Functional notes
// - set bit clocks its peripheral, clear bit disables
// - access to unclocked peripheral answers bus fault
// - deep-sleep gate register resets to zero
// - run, sleep, deep-sleep registers chosen per mode
// - sleep registers used only with auto gating
// - bit 24 gates analog comparator 0
// - bits 19..16 gate timers 3..0
// - bit 12 gates two-wire module 0
// - bits 5..4 gate sync serial 1..0
// - bits 2..0 gate async serial 2..0
// - unused bits read zero, ignore writes
// - deep-sleep gate register at offset 0x124
`include "dsg_consts.vh"
module dsg_top (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// peripheral access check from the system fabric
	input  wire        periph_access,
	input  wire [3:0]  periph_select,
	output reg         periph_fault,
	// peripheral clock enables and gated clocks
	output reg  [31:0] gate_enable,
	output wire [11:0] periph_clk,
	// interrupt
	output reg         irq
);
	reg  [31:0] run_gate_ctrl_1_reg;
	reg  [31:0] sleep_gate_ctrl_1_reg;
	reg  [31:0] deep_sleep_gate_ctrl_1_reg;
	reg  [31:0] run_clock_config_reg;
	reg  [1:0]  power_mode_reg;
	reg  [31:0] int_status_reg;
	reg  [31:0] int_mask_reg;
	reg  [31:0] gate_next;
	reg  [11:0] aw_addr_reg;
	reg         aw_held_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         w_held_reg;
	reg  [31:0] rd_data;
	reg  [1:0]  rd_resp;
	reg         wr_known;
	reg  [31:0] wr_word;
	reg  [31:0] ev_set;
	wire        auto_clock_gating;
	wire        wr_fire;
	wire [11:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0]  wr_strb;
	wire [11:0] periph_en;

	// gate bit positions at the width of a bit index
	localparam [4:0] pos_async0      = `DSG_BIT_ASYNC0;
	localparam [4:0] pos_sync0       = `DSG_BIT_SYNC0;
	localparam [4:0] pos_two_wire0   = `DSG_BIT_TWO_WIRE0;
	localparam [4:0] pos_counter0    = `DSG_BIT_COUNTER0;
	localparam [4:0] pos_comparator0 = `DSG_BIT_COMPARATOR0;

	// merge byte lanes onto an old word, keeping only the bits set in keep
	function [31:0] dsg_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		input [31:0] keep;
		integer i;
		begin
			dsg_merge = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					dsg_merge[i*8 +: 8] = new_val[i*8 +: 8];
			end
			dsg_merge = dsg_merge & keep;
		end
	endfunction

	// map a peripheral index onto its gate bit
	function [4:0] dsg_bit;
		input [3:0] sel;
		begin
			case (sel)
				4'h0: dsg_bit = pos_async0;
				4'h1: dsg_bit = pos_async0 + 5'd1;
				4'h2: dsg_bit = pos_async0 + 5'd2;
				4'h3: dsg_bit = pos_sync0;
				4'h4: dsg_bit = pos_sync0 + 5'd1;
				4'h5: dsg_bit = pos_two_wire0;
				4'h6: dsg_bit = pos_counter0;
				4'h7: dsg_bit = pos_counter0 + 5'd1;
				4'h8: dsg_bit = pos_counter0 + 5'd2;
				4'h9: dsg_bit = pos_counter0 + 5'd3;
				4'ha: dsg_bit = pos_comparator0;
				default: dsg_bit = 5'd3;
			endcase
		end
	endfunction

	assign auto_clock_gating = run_clock_config_reg[`DSG_BIT_AUTO_GATE];

	// run register outside low-power modes; sleep banks only with auto gating
	always @* begin
		gate_next = run_gate_ctrl_1_reg;
		if (auto_clock_gating) begin
			case (power_mode_reg)
				`DSG_MODE_SLEEP: gate_next = sleep_gate_ctrl_1_reg;
				`DSG_MODE_DEEP:  gate_next = deep_sleep_gate_ctrl_1_reg;
				default:         gate_next = run_gate_ctrl_1_reg;
			endcase
		end
	end

	// write channel: address and data taken in either order
	assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
	assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;

	always @* begin
		wr_known = 1'b1;
		wr_word = 32'h00000000;
		case (wr_addr)
			`DSG_OFF_RUN_GATE:   wr_word = run_gate_ctrl_1_reg;
			`DSG_OFF_SLEEP_GATE: wr_word = sleep_gate_ctrl_1_reg;
			`DSG_OFF_DEEP_GATE:  wr_word = deep_sleep_gate_ctrl_1_reg;
			`DSG_OFF_RUN_CFG:    wr_word = run_clock_config_reg;
			`DSG_OFF_POWER_MODE: wr_word = {30'h00000000, power_mode_reg};
			`DSG_OFF_INT_STATUS: wr_word = int_status_reg;
			`DSG_OFF_INT_MASK:   wr_word = int_mask_reg;
			`DSG_OFF_ACTIVE:     wr_word = gate_enable;
			default:             wr_known = 1'b0;
		endcase
	end

	// interrupt events: blocked access and a change of applied gates
	always @* begin
		ev_set = 32'h00000000;
		ev_set[`DSG_INT_FAULT] = periph_access & ~gate_enable[dsg_bit(periph_select)];
		ev_set[`DSG_INT_CHANGE] = (gate_next != gate_enable);
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DSG_RESP_OKAY;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			run_gate_ctrl_1_reg <= `DSG_GATE_RESET;
			sleep_gate_ctrl_1_reg <= `DSG_GATE_RESET;
			deep_sleep_gate_ctrl_1_reg <= `DSG_GATE_RESET;
			run_clock_config_reg <= 32'h00000000;
			power_mode_reg <= `DSG_MODE_RUN;
			int_status_reg <= 32'h00000000;
			int_mask_reg <= 32'h00000000;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			// ready pulses in the accept cycle; held copies cover the lag
			if (s_axi_awvalid & ~aw_held_reg & ~s_axi_awready & ~s_axi_bvalid) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid & ~w_held_reg & ~s_axi_wready & ~s_axi_bvalid) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `DSG_RESP_OKAY : `DSG_RESP_DECERR;
				case (wr_addr)
					`DSG_OFF_RUN_GATE:
						run_gate_ctrl_1_reg <= dsg_merge(wr_word, wr_data, wr_strb,
							`DSG_GATE_MASK);
					`DSG_OFF_SLEEP_GATE:
						sleep_gate_ctrl_1_reg <= dsg_merge(wr_word, wr_data, wr_strb,
							`DSG_GATE_MASK);
					// only gate bits are stored, rest read zero
					`DSG_OFF_DEEP_GATE:
						deep_sleep_gate_ctrl_1_reg <= dsg_merge(wr_word, wr_data, wr_strb,
							`DSG_GATE_MASK);
					`DSG_OFF_RUN_CFG:
						run_clock_config_reg <= dsg_merge(wr_word, wr_data, wr_strb,
							32'h08000000);
					`DSG_OFF_POWER_MODE:
						if (wr_strb[0] && wr_data[1:0] != 2'h3)
							power_mode_reg <= wr_data[1:0];
					`DSG_OFF_INT_MASK:
						int_mask_reg <= dsg_merge(wr_word, wr_data, wr_strb, `DSG_INT_MASK);
					default: ;
				endcase
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// write-one-to-clear, a new event wins over the clear
			if (wr_fire & (wr_addr == `DSG_OFF_INT_STATUS))
				int_status_reg <= ((int_status_reg & ~dsg_merge(32'h00000000, wr_data,
					wr_strb, `DSG_INT_MASK)) | ev_set) & `DSG_INT_MASK;
			else
				int_status_reg <= (int_status_reg | ev_set) & `DSG_INT_MASK;
		end
	end

	// read channel
	always @* begin
		rd_resp = `DSG_RESP_OKAY;
		case (s_axi_araddr)
			`DSG_OFF_RUN_GATE:   rd_data = run_gate_ctrl_1_reg;
			`DSG_OFF_SLEEP_GATE: rd_data = sleep_gate_ctrl_1_reg;
			`DSG_OFF_DEEP_GATE:  rd_data = deep_sleep_gate_ctrl_1_reg & `DSG_GATE_MASK;
			`DSG_OFF_RUN_CFG:    rd_data = run_clock_config_reg;
			`DSG_OFF_POWER_MODE: rd_data = {30'h00000000, power_mode_reg};
			`DSG_OFF_INT_STATUS: rd_data = int_status_reg;
			`DSG_OFF_INT_MASK:   rd_data = int_mask_reg;
			`DSG_OFF_ACTIVE:     rd_data = gate_enable;
			default: begin
				rd_data = 32'h00000000;
				rd_resp = `DSG_RESP_DECERR;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `DSG_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_resp;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// applied enables, fault answer and interrupt, all registered
	always @(posedge aclk) begin
		if (!aresetn) begin
			gate_enable <= `DSG_GATE_RESET;
			periph_fault <= 1'b0;
			irq <= 1'b0;
		end else begin
			gate_enable <= gate_next & `DSG_GATE_MASK;
			// judged on the gates applied now, not on the bank about to be applied
			periph_fault <= periph_access & ~gate_enable[dsg_bit(periph_select)];
			irq <= |(int_status_reg & int_mask_reg);
		end
	end

	assign periph_en = {gate_enable[pos_comparator0],
		gate_enable[pos_counter0 + 5'd3 : pos_counter0],
		gate_enable[pos_two_wire0],
		gate_enable[pos_sync0 + 5'd1 : pos_sync0],
		gate_enable[pos_async0 + 5'd2 : pos_async0], 1'b0};

	// one cell per peripheral; index 0 is an unused spare tied off
	genvar g;
	generate
		for (g = 0; g < `DSG_NUM_PERIPH; g = g + 1) begin : gate_cells
			dsg_clock_gate u_gate (
				.clk_in  (aclk),
				.enable  (periph_en[g]),
				.clk_out (periph_clk[g])
			);
		end
	endgenerate
endmodule

// File: test/deep_sleep_clock_gating_tb_top.sv
// self-checking bench for the deep-sleep clock gating block
`include "dsg_consts.vh"
module deep_sleep_clock_gating_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000, lf = 32'h00000008, d;
	logic [3:0]  s_axi_wstrb = 4'hf, sel = 4'h0, periph_select;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, gate_enable;
	logic        periph_access, periph_fault, irq;
	logic [11:0] periph_clk;
	int          errors = 0, n_checks = 0;
	always #5 aclk = ~aclk;
	dsg_top dut (.*);
	dsg_fabric_model fab (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic exp_fault(input logic [31:0] g, input logic [3:0] s);
		int b;
		b = s < 3 ? s : s < 5 ? s + 1 : s == 5 ? 12 : s < 10 ? s + 10 : s == 10 ? 24 : 3;
		return !g[b];
	endfunction
	function automatic logic [11:0] exp_clk(input logic [31:0] g);
		return {g[24], g[19:16], g[12], g[5:4], g[2:0], 1'b0};
	endfunction
	function automatic logic [1:0] exp_resp(input logic [11:0] a);
		case (a)
			`DSG_OFF_RUN_GATE, `DSG_OFF_SLEEP_GATE, `DSG_OFF_DEEP_GATE, `DSG_OFF_RUN_CFG,
			`DSG_OFF_POWER_MODE, `DSG_OFF_INT_STATUS, `DSG_OFF_INT_MASK, `DSG_OFF_ACTIVE:
				return `DSG_RESP_OKAY;
			default:
				return `DSG_RESP_DECERR;
		endcase
	endfunction
	task automatic wrap_up();
		if (errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 40);
		s_axi_bready <= 1'b0;
		if (n >= 40) errors++;
		check({30'h0, s_axi_bresp}, {30'h0, exp_resp(a)});
		@(posedge aclk);
	endtask
	// rready rises only after rvalid, so the slave must hold its answer a cycle
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (!s_axi_rready) s_axi_rready <= s_axi_rvalid;
			n++;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
		s_axi_rready <= 1'b0;
		if (n >= 40) errors++;
		check(s_axi_rdata, exp);
		check({30'h0, s_axi_rresp}, {30'h0, er});
		@(posedge aclk);
	endtask
	task automatic mode_chk(input logic [31:0] cfg, input logic [1:0] m, input logic [31:0] e);
		wr(`DSG_OFF_RUN_CFG, cfg);
		wr(`DSG_OFF_POWER_MODE, {30'h0, m});
		@(posedge aclk);
		check(gate_enable, e);
	endtask
	task automatic probe(input logic [3:0] s, input logic exp);
		sel <= s;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (2) @(posedge aclk);
		check({31'h0, periph_fault}, {31'h0, exp});
	endtask
	// gated clocks follow aclk in its high phase and stay low in its low phase
	task automatic clk_chk(input logic [31:0] g);
		@(posedge aclk);
		#2;
		check({20'h0, periph_clk}, {20'h0, exp_clk(g)});
		#5;
		check({20'h0, periph_clk}, 32'h00000000);
		@(posedge aclk);
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(`DSG_OFF_DEEP_GATE, 32'h00000000, 2'h0);
		rd_chk(12'h128, 32'h00000000, 2'h3);
		wr(12'h128, 32'hffffffff);
		rd_chk(`DSG_OFF_DEEP_GATE, 32'h00000000, 2'h0);
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			d = i == 0 ? 32'hffffffff : lf;
			wr(`DSG_OFF_DEEP_GATE, d);
			rd_chk(`DSG_OFF_DEEP_GATE, d & 32'h010f1037, 2'h0);
		end
		// read-modify-write that carries the unused bits back as read
		d = (d & 32'h010f1037) | 32'h00000010;
		wr(`DSG_OFF_DEEP_GATE, d);
		rd_chk(`DSG_OFF_DEEP_GATE, d, 2'h0);
		s_axi_wstrb <= 4'h4;
		wr(`DSG_OFF_DEEP_GATE, 32'hffffffff);
		s_axi_wstrb <= 4'hf;
		rd_chk(`DSG_OFF_DEEP_GATE, (d & 32'hff00ffff) | 32'h000f0000, 2'h0);
		wr(`DSG_OFF_RUN_GATE, 32'h01041015);
		wr(`DSG_OFF_SLEEP_GATE, 32'h000a0020);
		wr(`DSG_OFF_DEEP_GATE, 32'h00011006);
		mode_chk(32'h00000000, 2'h2, 32'h01041015);
		mode_chk(32'h08000000, 2'h2, 32'h00011006);
		clk_chk(32'h00011006);
		mode_chk(32'h08000000, 2'h1, 32'h000a0020);
		wr(`DSG_OFF_POWER_MODE, 32'h00000003);
		rd_chk(`DSG_OFF_POWER_MODE, 32'h00000001, 2'h0);
		mode_chk(32'h08000000, 2'h0, 32'h01041015);
		clk_chk(32'h01041015);
		rd_chk(`DSG_OFF_ACTIVE, 32'h01041015, 2'h0);
		wr(`DSG_OFF_INT_STATUS, 32'h00000003);
		wr(`DSG_OFF_INT_MASK, 32'h00000000);
		probe(4'hf, 1'b1);
		check({31'h0, irq}, 32'h0);
		wr(`DSG_OFF_INT_STATUS, 32'h00000003);
		wr(`DSG_OFF_INT_MASK, 32'h00000001);
		for (int s = 0; s < 16; s++) probe(s[3:0], exp_fault(32'h01041015, s[3:0]));
		check({31'h0, irq}, 32'h1);
		wr(`DSG_OFF_INT_STATUS, 32'h00000003);
		repeat (2) @(posedge aclk);
		check({31'h0, irq}, 32'h0);
		rd_chk(`DSG_OFF_INT_STATUS, 32'h00000000, 2'h0);
		// second reset in mid-run with gates open
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(gate_enable, 32'h00000000);
		rd_chk(`DSG_OFF_DEEP_GATE, 32'h00000000, 2'h0);
		wrap_up();
	end
	initial begin
		#50us;
		errors++;
		wrap_up();
	end
endmodule

// File: test/dsg_checker_asserts.sv
// port-level checks for the deep-sleep clock gating block
module dsg_checker (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	// peripheral side
	input wire logic        periph_access,
	input wire logic [3:0]  periph_select,
	input wire logic        periph_fault,
	input wire logic [31:0] gate_enable,
	input wire logic        irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// selects 11..15 land on reserved bit 3, which never clocks anything
	function automatic int gate_bit(input logic [3:0] s);
		return s < 3 ? s : s < 5 ? s + 1 : s == 5 ? 12 : s < 10 ? s + 10 : s == 10 ? 24 : 3;
	endfunction
	fault_off_a: assert property (
		periph_access && !gate_enable[gate_bit(periph_select)] |=> periph_fault)
		else $error("no fault for gated peripheral");
	fault_on_a: assert property (
		periph_access && gate_enable[gate_bit(periph_select)] |=> !periph_fault)
		else $error("fault for clocked peripheral");
	fault_idle_a: assert property (!periph_access |=> !periph_fault)
		else $error("fault without access");
	reserved_zero_a: assert property ((gate_enable & ~32'h010f1037) == 32'h0)
		else $error("reserved gate bit set");
	reset_clear_a: assert property (disable iff (1'b0)
		!aresetn |=> gate_enable == 32'h0 && !irq && !s_axi_bvalid && !periph_fault)
		else $error("state not cleared by reset");
	write_resp_a: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	read_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	read_answer_a: assert property (
		s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |-> ##[1:2] s_axi_rvalid)
		else $error("read answer late");
	fault_seen_c: cover property (periph_fault);
	irq_seen_c: cover property (irq);
	decerr_seen_c: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule
bind dsg_top dsg_checker chk (.*);

// File: test/dsg_fabric_model.sv
// processor-side model issuing single-cycle peripheral accesses
module dsg_fabric_model (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// request from the bench
	input  wire logic       go,
	input  wire logic [3:0] sel,
	// access toward the gating block
	output logic            periph_access,
	output logic [3:0]      periph_select
);
	timeunit 1ns;
	timeprecision 1ps;
	// select scrambles when idle so a stale value is never trusted
	always @(posedge aclk) begin
		if (!aresetn) begin
			periph_access <= 1'b0;
			periph_select <= 4'h0;
		end else begin
			periph_access <= go;
			periph_select <= go ? sel : ~periph_select;
		end
	end
endmodule
